// ===== ssm_port.sv
// synchronous serial port, clock master or slave, with ahb-lite registers
// Behaviour
// - sync, clock source, port enable make master
// - both receive enables clear means transmit
// - master drives clock pin, driver auto enabled
// - one clock per bit, none extra
// - transmit drives data, data driver enabled; clock driver only as master
// - holding write starts; waits while shifter busy
// - empty shifter loads holding at once
// - data changes on leading clock edge
// - receive turns data driver off
// - either receive enable starts reception
// - single receive: one character, then self-clear
// - continuous clear stops clock, drops partial
// - both set: single clears, continuous continues
// - sample data on trailing clock edge
// - two-entry fifo, flag while unread entries
// - third character overruns, blocks further reception
// - overrun cleared by continuous clear, or by read while continuous is off
// - port enable clear resets sequencer, holding, fifo, overrun and single receive; other control bits keep
// - nine-bit receive; ninth bit from oldest entry
// - slave: clock pin input, bit per clock
// - sync divider: clock over four times (n+1)
// - divider write restarts baud timer
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module ssm_port
  import ssm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // clock_line pin
  input wire logic clock_line_i,
  output logic clock_line_o,
  output logic clock_line_oe_n,
  // data_line pin
  input wire logic data_line_i,
  output logic data_line_o,
  output logic data_line_oe_n
);
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] rx_ctrl_reg; // bits 7..2 control, ovr/receive_ninth_bit come from state
  logic [7:0] tx_ctrl_reg;
  logic [7:0] baud_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] hold_reg; // transmit_holding
  logic hold9_reg; // ninth bit captured with the holding write
  logic hold_full_reg; // holding occupied, transmit_flag is its inverse while port and transmitter are enabled
  logic [8:0] tsr_reg; // transmit_shift_register, never mapped
  logic [8:0] rsr_reg; // receive_shift_register
  logic [8:0] fifo_reg [2]; // receive fifo storage
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] count_reg;
  logic overrun_reg;
  logic [3:0] bit_cnt_reg;
  logic [3:0] char_bits_reg;
  logic [9:0] baud_cnt_reg; // counts 2*(n+1) system clocks per half bit
  logic sck_reg; // master clock level
  logic slv_clk_d_reg; // previous sampled slave clock
  ssm_state_t state_reg;
  ssm_req_t req_reg;
  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic port_en, is_master, sync_mode, rx_dir, wr_rx_ctrl, wr_tx_hold;
  logic wr_baud, rd_rx_data, half_tick, lead, trail, busy, fifo_full;
  logic ovr_set;
  assign port_en = rx_ctrl_reg[RC_PORT_EN];
  assign sync_mode = tx_ctrl_reg[TC_SYNC];
  assign is_master = sync_mode & tx_ctrl_reg[TC_CLK_SRC] & port_en;
  // either receive enable selects receive direction
  assign rx_dir = rx_ctrl_reg[RC_SINGLE] | rx_ctrl_reg[RC_CONT];
  assign wr_rx_ctrl = req_reg.valid & req_reg.write &
                      (req_reg.addr == ADDR_RX_CTRL);
  assign wr_tx_hold = req_reg.valid & req_reg.write &
                      (req_reg.addr == ADDR_TX_HOLD);
  assign wr_baud = req_reg.valid & req_reg.write &
                   (req_reg.addr == ADDR_BAUD);
  assign rd_rx_data = req_reg.valid & ~req_reg.write &
                      (req_reg.addr == ADDR_RX_DATA);
  assign fifo_full = (count_reg == FIFO_DEPTH);
  assign busy = (state_reg != SSM_IDLE);
  // divider: half period is 2*(n+1) clocks, so a full bit is 4*(n+1)
  function automatic logic [9:0] half_period(input logic [7:0] n);
    half_period = {1'b0, ({1'b0, n} + 9'h001)} << 1;
  endfunction : half_period
  assign half_tick = is_master & busy &
                     (baud_cnt_reg == half_period(baud_reg) - 10'h001);
  // slave clock edges from the synchronous pin input
  assign lead = is_master ? (half_tick & ~sck_reg)
              : (busy & clock_line_i & ~slv_clk_d_reg);
  assign trail = is_master ? (half_tick & sck_reg)
               : (busy & ~clock_line_i & slv_clk_d_reg);
  assign ovr_set = trail & (state_reg == SSM_RX) &
                   (bit_cnt_reg == char_bits_reg - 4'h1) & fifo_full;
  // ----------------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ----------------------------------------------------------------------
  // capture the address phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      req_reg <= '0;
    end else if (hready) begin
      req_reg.valid <= hsel & (htrans == HTRANS_NONSEQ);
      req_reg.write <= hwrite;
      req_reg.addr <= haddr;
    end else begin
      req_reg.valid <= 1'b0;
    end
  end
  // read mux, registered so data stands in the data phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hrdata <= '0;
    end else if (hsel & hready & (htrans == HTRANS_NONSEQ) & ~hwrite) begin
      unique case (haddr)
        ADDR_RX_CTRL: hrdata <= {24'h0, rx_ctrl_reg[7:2], overrun_reg,
                                 rx_ctrl_reg[RC_RX9] &
                                 fifo_reg[rd_ptr_reg][8]};
        ADDR_TX_CTRL: hrdata <= {24'h0, tx_ctrl_reg[7:2], ~busy,
                                 tx_ctrl_reg[TC_TRANSMIT_NINTH_BIT]};
        ADDR_BAUD: hrdata <= {24'h0, baud_reg};
        // low eight bits of the oldest entry
        ADDR_RX_DATA: hrdata <= {24'h0, fifo_reg[rd_ptr_reg][7:0]};
        // transmit_flag only while the transmitter is enabled, so 0 at reset
        ADDR_IRQ_FLAGS: hrdata <= {26'h0, count_reg != 2'h0,
                                   port_en & tx_ctrl_reg[TC_TX_EN] &
                                   ~hold_full_reg, 4'h0};
        ADDR_IRQ_EN: hrdata <= {24'h0, irq_en_reg};
        default: hrdata <= '0; // holding register is write only
      endcase
    end
  end
  // slave never stalls and never errors
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  // rx control; hardware clears single receive after one character
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_ctrl_reg <= RX_CTRL_RESET;
    end else if (wr_rx_ctrl) begin
      rx_ctrl_reg <= {hwdata[7:2], 2'b00};
    end else if (!port_en) begin
      rx_ctrl_reg[RC_SINGLE] <= 1'b0;
    end else if (trail & (state_reg == SSM_RX) &
                 (bit_cnt_reg == char_bits_reg - 4'h1)) begin
      rx_ctrl_reg[RC_SINGLE] <= 1'b0;
    end
  end
  // tx control, baud, irq enables
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_ctrl_reg <= TX_CTRL_RESET;
      baud_reg <= BAUD_RESET;
      irq_en_reg <= '0;
    end else begin
      if (req_reg.valid & req_reg.write & (req_reg.addr == ADDR_TX_CTRL))
        tx_ctrl_reg <= {hwdata[7:2], 1'b0, hwdata[0]};
      if (wr_baud)
        baud_reg <= hwdata[7:0];
      if (req_reg.valid & req_reg.write & (req_reg.addr == ADDR_IRQ_EN))
        irq_en_reg <= hwdata[7:0];
    end
  end
  // ----------------------------------------------------------------------
  // baud timer and master clock
  // ----------------------------------------------------------------------
  // restarted on every divider write, counts only while a character runs
  always_ff @(posedge clk) begin
    if (!resetn || wr_baud || !busy) begin
      baud_cnt_reg <= '0;
    end else if (half_tick) begin
      baud_cnt_reg <= '0;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 10'h001;
    end
  end
  // clock toggles only inside a character, so pulses equal bits
  always_ff @(posedge clk) begin
    if (!resetn || !busy) begin
      sck_reg <= 1'b0;
    end else if (half_tick) begin
      sck_reg <= ~sck_reg;
    end
  end
  // slave clock history, pin input taken as synchronous
  always_ff @(posedge clk) begin
    if (!resetn) begin
      slv_clk_d_reg <= 1'b0;
    end else begin
      slv_clk_d_reg <= clock_line_i;
    end
  end
  // ----------------------------------------------------------------------
  // transmit holding
  // ----------------------------------------------------------------------
  logic tx_load;
  assign tx_load = (state_reg == SSM_IDLE) & hold_full_reg & port_en &
                   sync_mode & tx_ctrl_reg[TC_TX_EN] & ~rx_dir;
  // a write parks the character until the shifter frees
  always_ff @(posedge clk) begin
    if (!resetn || !port_en) begin
      hold_full_reg <= 1'b0;
      hold_reg <= '0;
      hold9_reg <= 1'b0;
    end else if (wr_tx_hold) begin
      hold_full_reg <= 1'b1;
      hold_reg <= hwdata[7:0];
      hold9_reg <= tx_ctrl_reg[TC_TRANSMIT_NINTH_BIT];
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // character sequencer
  // ----------------------------------------------------------------------
  logic last_bit;
  assign last_bit = (bit_cnt_reg == char_bits_reg - 4'h1);
  always_ff @(posedge clk) begin
    if (!resetn || !port_en) begin
      state_reg <= SSM_IDLE;
      bit_cnt_reg <= '0;
      char_bits_reg <= BITS_8;
      tsr_reg <= '0;
      rsr_reg <= '0;
    end else begin
      unique case (state_reg)
        SSM_IDLE: begin
          bit_cnt_reg <= '0;
          if (tx_load) begin
            // load at once, first bit is on the pin before the first lead
            state_reg <= SSM_TX;
            tsr_reg <= {hold9_reg, hold_reg};
            char_bits_reg <= tx_ctrl_reg[TC_TX9] ? BITS_9 : BITS_8;
          end else if (sync_mode & rx_dir & ~overrun_reg) begin
            state_reg <= SSM_RX;
            char_bits_reg <= rx_ctrl_reg[RC_RX9] ? BITS_9 : BITS_8;
          end
        end
        SSM_TX: begin
          // shift on leading edge after the first bit
          if (lead & (bit_cnt_reg != 4'h0 || sck_reg)) begin
            tsr_reg <= tsr_reg >> 1;
          end
          if (trail) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (last_bit) state_reg <= SSM_IDLE;
          end
        end
        SSM_RX: begin
          if (!rx_dir) begin
            state_reg <= SSM_IDLE; // partial character dropped
          end else if (trail) begin
            // lsb first into the top, aligned at completion
            rsr_reg <= {data_line_i, rsr_reg[8:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (last_bit) state_reg <= SSM_IDLE;
          end
        end
      endcase
    end
  end
  // assembled character, right aligned by its length
  logic [8:0] rx_char;
  assign rx_char = (char_bits_reg == BITS_9) ? {data_line_i, rsr_reg[8:1]}
                 : {1'b0, data_line_i, rsr_reg[8:2]};
  // ----------------------------------------------------------------------
  // receive fifo and overrun
  // ----------------------------------------------------------------------
  logic push, pop;
  assign push = trail & (state_reg == SSM_RX) & last_bit & rx_dir &
                ~fifo_full;
  assign pop = rd_rx_data & (count_reg != 2'h0);
  always_ff @(posedge clk) begin
    if (!resetn || !port_en) begin
      count_reg <= '0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      fifo_reg[0] <= '0;
      fifo_reg[1] <= '0;
    end else begin
      if (push) begin
        fifo_reg[wr_ptr_reg] <= rx_char;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  // overrun keeps fifo contents; set wins over clear
  always_ff @(posedge clk) begin
    if (!resetn || !port_en) begin
      overrun_reg <= 1'b0;
    end else if (ovr_set) begin
      overrun_reg <= 1'b1;
    end else if (rx_ctrl_reg[RC_CONT] & wr_rx_ctrl & ~hwdata[RC_CONT]) begin
      overrun_reg <= 1'b0;
    end else if (rd_rx_data & ~rx_ctrl_reg[RC_CONT]) begin
      overrun_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  // clock driver on in master mode, off as slave
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clock_line_o <= 1'b0;
      clock_line_oe_n <= 1'b1;
      data_line_o <= 1'b0;
      data_line_oe_n <= 1'b1;
    end else begin
      clock_line_o <= sck_reg;
      clock_line_oe_n <= ~is_master;
      data_line_o <= tsr_reg[0];
      // data driven in transmit, released in receive
      data_line_oe_n <= ~(port_en & sync_mode & ~rx_dir);
    end
  end
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  overrun_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    ovr_set && port_en |=> overrun_reg)
    else $error("overrun not raised on third character");
  fifo_bound_a: assert property (@(posedge clk) disable iff (!resetn)
    count_reg <= FIFO_DEPTH)
    else $error("fifo count beyond depth");
  rx_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    push && count_reg == 2'h0 && !pop |=> count_reg == 2'h1)
    else $error("push did not land in fifo");
  no_push_full_a: assert property (@(posedge clk) disable iff (!resetn)
    fifo_full && !pop && port_en |=> count_reg == FIFO_DEPTH)
    else $error("full fifo lost contents");
  port_reset_a: assert property (@(posedge clk) disable iff (!resetn)
    !port_en |=> state_reg == SSM_IDLE && !overrun_reg)
    else $error("port disable did not reset unit");
  cont_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SSM_RX && !rx_dir && port_en |=> state_reg == SSM_IDLE)
    else $error("receive did not stop on enable clear");
  clk_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !busy |=> !sck_reg)
    else $error("master clock toggled outside character");
  rx_drv_off_a: assert property (@(posedge clk) disable iff (!resetn)
    rx_dir |=> data_line_oe_n)
    else $error("data driver on during receive");
  clk_drv_a: assert property (@(posedge clk) disable iff (!resetn)
    is_master |=> !clock_line_oe_n)
    else $error("clock driver off in master mode");
endmodule : ssm_port

// ===== ssm_pkg.sv
// package of register map, field positions and types for the serial port
package ssm_pkg;
  // ----------------------------------------------------------------------
  // register byte addresses (one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_CTRL = 8'h00; // serial_rx_status_control
  localparam logic [7:0] ADDR_TX_CTRL = 8'h04; // serial_tx_status_control
  localparam logic [7:0] ADDR_BAUD = 8'h08; // baud_divider
  localparam logic [7:0] ADDR_TX_HOLD = 8'h0c; // transmit_holding
  localparam logic [7:0] ADDR_RX_DATA = 8'h10; // receive_data
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h14; // peripheral_irq_flags
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18; // peripheral_irq_enables
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  // rx control: port_enable, rx9, single, continuous, addr det, -, ovr, receive_ninth_bit
  localparam int RC_PORT_EN = 7;
  localparam int RC_RX9 = 6;
  localparam int RC_SINGLE = 5;
  localparam int RC_CONT = 4;
  localparam int RC_ADDR_DET = 3;
  localparam int RC_OVERRUN = 1;
  localparam int RC_RECEIVE_NINTH_BIT = 0;
  // tx control: clk src, tx9, tx en, sync, -, high speed, shift empty, transmit_ninth_bit
  localparam int TC_CLK_SRC = 7;
  localparam int TC_TX9 = 6;
  localparam int TC_TX_EN = 5;
  localparam int TC_SYNC = 4;
  localparam int TC_HIGH_SPEED = 2;
  localparam int TC_SHIFT_EMPTY = 1;
  localparam int TC_TRANSMIT_NINTH_BIT = 0;
  // irq flags / enables
  localparam int IF_RX = 5;
  localparam int IF_TX = 4;
  // ----------------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_CTRL_RESET = 8'h02;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2; // two character receive fifo
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SSM_IDLE, SSM_TX, SSM_RX} ssm_state_t;
  // one ahb-lite address phase as captured by the slave
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ssm_req_t;
  // two signals of one two-way pin; oe_n low means driven
  typedef struct packed {
    logic o;
    logic oe_n;
  } ssm_pin_t;
endpackage : ssm_pkg

// ===== ssm_slave.sv
// behavioural synchronous slave on the far side of the serial port
`timescale 1ns/1ps
module ssm_slave (
  // wires of the link
  input wire logic sck,
  input wire logic dat_in,
  input wire logic port_drives,
  output logic dat_out,
  // bench control
  input wire logic clear,
  input wire logic [8:0] send_word,
  input wire logic [3:0] send_bits,
  output logic [31:0] got_word
);
  logic [3:0] idx; // next bit of send_word to present
  initial begin
    idx = 4'h0;
    dat_out = 1'b0;
    got_word = 32'h0;
  end
  // ----------
  // restart both directions between scenarios
  // ----------
  always @(posedge clear) begin
    idx = 4'h0;
    got_word = 32'h0;
  end
  // present on the leading edge; a released line shows no stale bit
  always @(posedge sck) begin
    if (!port_drives) dat_out <= send_word[idx];
    else dat_out <= ~dat_out;
  end
  // take the port's bit, or step to our next one, on the trailing edge
  always @(negedge sck) begin
    if (port_drives) got_word <= {dat_in, got_word[31:1]};
    else idx <= (idx == send_bits - 4'h1) ? 4'h0 : idx + 4'h1;
  end
endmodule : ssm_slave

// ===== ssm_port_tb.sv
// self-checking testbench of the synchronous serial port
`timescale 1ns/1ps
module ssm_port_tb;
  import ssm_pkg::*;
  // ----------
  // bench signals
  // ----------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // whole words only
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic cl_o, cl_oe_n, dl_o, dl_oe_n; // pin pieces from the port
  logic sck_tb = 1'b0; // bench clock for slave mode, still between frames
  logic slv_out, slv_clear = 1'b0;
  logic [8:0] slv_word = 9'h0;
  logic [3:0] slv_bits = 4'h8;
  logic [31:0] slv_got, q, w;
  logic [31:0] r; // word the slave sends; bus calls overwrite q
  logic [31:0] seed = 32'he64e;
  int bad_count = 0, total_checks = 0, cyc = 0, fe_cnt = 0;
  time t_first, t_mid;
  logic [7:0] b, d1, d2;
  logic [7:0] rst_a [7] = '{ADDR_RX_CTRL, ADDR_TX_CTRL, ADDR_BAUD,
    ADDR_RX_DATA, ADDR_IRQ_FLAGS, ADDR_IRQ_EN, 8'h1c};
  logic [7:0] rst_v [7] = '{RX_CTRL_RESET, TX_CTRL_RESET, BAUD_RESET,
    8'h00, 8'h00, 8'h00, 8'h00};
  // wire levels worked out from the port's enables; the slave and bench drive whenever the port releases
  wire clock_line = cl_oe_n ? sck_tb : cl_o;
  wire data_line = dl_oe_n ? slv_out : dl_o;
  always #25 clk = ~clk;
  // ----------
  // design and far-side model
  // ----------
  ssm_port dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .clock_line_i(clock_line), .clock_line_o(cl_o),
    .clock_line_oe_n(cl_oe_n), .data_line_i(data_line),
    .data_line_o(dl_o), .data_line_oe_n(dl_oe_n));
  ssm_slave slv (.sck(clock_line), .dat_in(data_line),
    .port_drives(!dl_oe_n), .dat_out(slv_out), .clear(slv_clear),
    .send_word(slv_word), .send_bits(slv_bits), .got_word(slv_got));
  // count trailing edges and note when the first and eighth fall
  always @(negedge clock_line) begin
    fe_cnt++;
    if (fe_cnt == 1) t_first = $time;
    if (fe_cnt == 8) t_mid = $time;
  end
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // time from first to last trailing edge of n bits at divider dv
  function automatic time span(input logic [7:0] dv, input int n);
    return (n - 1) * 4 * (dv + 1) * 50;
  endfunction : span
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic hold(); // wait until hready is seen high at an edge
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : hold
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    q = hrdata;
  endtask : bus
  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rdm
  task automatic restart(); // fresh slave state and edge count
    fe_cnt = 0;
    slv_clear <= 1'b1;
    @(posedge clk);
    slv_clear <= 1'b0;
  endtask : restart
  task automatic frame(input int n); // n edges, then none more
    while (fe_cnt < n) @(posedge clk);
    repeat (80) @(posedge clk);
    chk(32'(fe_cnt), 32'(n));
  endtask : frame
  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    foreach (rst_a[i]) rdm(rst_a[i], 32'hffffffff, {24'h0, rst_v[i]});
    chk({30'h0, cl_oe_n, dl_oe_n}, 32'h3);
    w = rnd();
    bus(1'b1, ADDR_IRQ_EN, w & 32'h30);
    rdm(ADDR_IRQ_EN, 32'hffffffff, w & 32'h30);
    // master transmit: two characters back to back, random divider
    q = rnd();
    b = {6'h0, q[1:0]};
    d1 = q[15:8];
    d2 = q[23:16];
    bus(1'b1, ADDR_BAUD, {24'h0, b});
    rdm(ADDR_BAUD, 32'hffffffff, {24'h0, b});
    bus(1'b1, ADDR_TX_CTRL, 32'hb0);
    bus(1'b1, ADDR_RX_CTRL, 32'h80);
    repeat (2) @(posedge clk); // pin enables follow the write a cycle later
    chk({30'h0, cl_oe_n, dl_oe_n}, 32'h0);
    restart();
    bus(1'b1, ADDR_TX_HOLD, {24'h0, d1});
    bus(1'b1, ADDR_TX_HOLD, {24'h0, d2});
    rdm(ADDR_IRQ_FLAGS, 32'h10, 32'h0);
    frame(16);
    chk({16'h0, slv_got[31:16]}, {16'h0, d2, d1});
    chk(32'(t_mid - t_first), 32'(span(b, 8)));
    rdm(ADDR_TX_CTRL, 32'hff, 32'hb2);
    rdm(ADDR_IRQ_FLAGS, 32'h10, 32'h10);
    // nine-bit transmit, ninth bit last
    bus(1'b1, ADDR_TX_CTRL, 32'hf1);
    restart();
    bus(1'b1, ADDR_TX_HOLD, {24'h0, d1});
    frame(9);
    chk({23'h0, slv_got[31:23]}, {23'h0, 1'b1, d1});
    // single receive of eight bits
    bus(1'b1, ADDR_TX_CTRL, 32'hb0);
    r = rnd();
    slv_word <= r[8:0];
    restart();
    bus(1'b1, ADDR_RX_CTRL, 32'ha0);
    repeat (2) @(posedge clk);
    chk({31'h0, dl_oe_n}, 32'h1);
    frame(8);
    rdm(ADDR_IRQ_FLAGS, 32'h20, 32'h20);
    rdm(ADDR_RX_CTRL, 32'hfe, 32'h80);
    rdm(ADDR_RX_DATA, 32'hffffffff, {24'h0, r[7:0]});
    rdm(ADDR_IRQ_FLAGS, 32'h20, 32'h0);
    // single receive of nine bits, ninth bit read first
    slv_bits <= 4'h9;
    restart();
    bus(1'b1, ADDR_RX_CTRL, 32'he0);
    frame(9);
    rdm(ADDR_RX_CTRL, 32'h1, {31'h0, r[8]});
    rdm(ADDR_RX_DATA, 32'hff, {24'h0, r[7:0]});
    // both enables, continuous run into overrun
    slv_bits <= 4'h8;
    restart();
    bus(1'b1, ADDR_RX_CTRL, 32'hb0);
    while (fe_cnt < 24) @(posedge clk);
    repeat (20) @(posedge clk);
    rdm(ADDR_RX_CTRL, 32'hfe, 32'h92);
    repeat (2) rdm(ADDR_RX_DATA, 32'hff, {24'h0, r[7:0]});
    rdm(ADDR_IRQ_FLAGS, 32'h20, 32'h0);
    bus(1'b1, ADDR_RX_CTRL, 32'h80);
    rdm(ADDR_RX_CTRL, 32'hff, 32'h80);
    // continuous receive dropped in mid-character
    restart();
    bus(1'b1, ADDR_RX_CTRL, 32'h90);
    repeat (20) @(posedge clk);
    bus(1'b1, ADDR_RX_CTRL, 32'h80);
    // the pin lags the stop; let a last fall to idle pass before counting
    repeat (4) @(posedge clk);
    w = 32'(fe_cnt);
    repeat (100) @(posedge clk);
    chk(32'(fe_cnt), w);
    rdm(ADDR_IRQ_FLAGS, 32'h20, 32'h0);
    // slave mode: bench makes the clock
    bus(1'b1, ADDR_TX_CTRL, 32'h10);
    r = rnd();
    slv_word <= {1'b0, r[7:0]};
    restart();
    bus(1'b1, ADDR_RX_CTRL, 32'h90);
    chk({31'h0, cl_oe_n}, 32'h1);
    repeat (8) begin
      repeat (4) @(posedge clk);
      sck_tb <= 1'b1;
      repeat (4) @(posedge clk);
      sck_tb <= 1'b0;
    end
    repeat (8) @(posedge clk);
    rdm(ADDR_RX_DATA, 32'hff, {24'h0, r[7:0]});
    // port off releases both pins
    bus(1'b1, ADDR_RX_CTRL, 32'h00);
    repeat (2) @(posedge clk);
    chk({30'h0, cl_oe_n, dl_oe_n}, 32'h3);
    test_done();
  end
endmodule : ssm_port_tb
